// [hdl/msp_spi_port.v]
// Serial slave port into the monitor register space
// Function
// - Four pins: select, clock, data in, out
// - Capture on clock fall, MSB first
// - Read data shifts out on clock rise
// - Select high: ignore pins, output released
// - First byte: D7 read, D6 write
// - Pointer bits D5..D0 select register
// - Both flags: read then write same register
// - Banked register with a flag set: next byte is subpointer
// - Write-only frame keeps output released
// - No flags: pointer update, sequencer reinit
// - Frame length follows the command
// - Sixteen-bit data travels D15 first
// - Reserved bits accepted with any value
`include "msp_defines.vh"
module msp_spi_port (
	input wire sys_clk,
	input wire rst,
	input wire spi_cs_n,
	input wire spi_sclk,
	input wire spi_din,
	output wire spi_dout,
	output wire spi_dout_oe,
	output wire frame_start,
	output wire ptr_update,
	output wire seq_reinit,
	output wire [5:0] reg_addr,
	output wire [7:0] reg_sub,
	output wire reg_banked,
	output wire reg_rd_en,
	input wire [15:0] reg_rd_data,
	output wire reg_wr_en,
	output wire reg_wr_byte,
	output wire [15:0] reg_wr_data
);
	localparam ST_PTR = 2'b00;
	localparam ST_SUB = 2'b01;
	localparam ST_DATA = 2'b10;
	localparam ST_DONE = 2'b11;

	wire [2:0] pins_q;
	wire cs_n_q;
	wire sclk_q;
	wire din_q;
	wire sclk_fall;
	wire sclk_rise;
	wire cs_fall;
	wire cs_rise;
	wire [7:0] byte_in;
	wire ptr_in_bank;
	// Sequencer step strobes
	wire ptr_done;
	wire sub_done;
	wire word_done;
	wire null_ptr;
	wire byte_end;
	wire shift_out;

	reg sclk_prev_ff;
	reg cs_prev_ff;
	reg [1:0] state_ff;
	reg [4:0] bit_cnt_ff;
	reg [15:0] rx_ff;
	reg [15:0] tx_ff;
	reg rd_flag_ff;
	reg wr_flag_ff;
	reg rd_pend_ff;
	reg dout_ff;
	reg dout_oe_ff;
	reg frame_start_ff;
	reg ptr_update_ff;
	reg seq_reinit_ff;
	reg [5:0] reg_addr_ff;
	reg [7:0] reg_sub_ff;
	reg reg_banked_ff;
	reg reg_rd_en_ff;
	reg reg_wr_en_ff;
	reg reg_wr_byte_ff;
	reg [15:0] reg_wr_data_ff;
	// Next-state values of the sequencer
	reg [1:0] nxt_state;
	reg [4:0] nxt_bit_cnt;

	// Pins cross into the system clock domain; select idles high
	msp_sync #(
		.WIDTH(3),
		.RST_VAL(3'h4)
	) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in({spi_cs_n, spi_sclk, spi_din}),
		.sync_out(pins_q)
	);

	assign cs_n_q = pins_q[2];
	assign sclk_q = pins_q[1];
	assign din_q = pins_q[0];
	assign sclk_fall = sclk_prev_ff & ~sclk_q & ~cs_n_q;
	assign sclk_rise = ~sclk_prev_ff & sclk_q & ~cs_n_q;
	assign cs_fall = cs_prev_ff & ~cs_n_q;
	assign cs_rise = ~cs_prev_ff & cs_n_q;
	// Byte completed by the bit now arriving, MSB first
	assign byte_in = {rx_ff[6:0], din_q};
	assign ptr_in_bank = (byte_in[`MSP_PTR_ADDR_HI:`MSP_PTR_ADDR_LO] >= `MSP_BANK_LO) &&
		(byte_in[`MSP_PTR_ADDR_HI:`MSP_PTR_ADDR_LO] <= `MSP_BANK_HI);

	always @(posedge sys_clk) begin
		if (rst) begin
			sclk_prev_ff <= 1'b0;
			cs_prev_ff <= 1'b1;
		end else begin
			sclk_prev_ff <= sclk_q;
			cs_prev_ff <= cs_n_q;
		end
	end

	// Step strobes for the frame sequencer
	assign ptr_done = sclk_fall && (state_ff == ST_PTR) &&
		(bit_cnt_ff == `MSP_BYTE_BITS - 5'h01);
	assign sub_done = sclk_fall && (state_ff == ST_SUB) &&
		(bit_cnt_ff == `MSP_BYTE_BITS - 5'h01);
	assign word_done = sclk_fall && (state_ff == ST_DATA) &&
		(bit_cnt_ff == `MSP_WORD_BITS - 5'h01);
	assign null_ptr = ~byte_in[`MSP_PTR_RD_BIT] & ~byte_in[`MSP_PTR_WR_BIT];
	// Select rise after exactly one data byte
	assign byte_end = cs_rise && (state_ff == ST_DATA) && wr_flag_ff &&
		(bit_cnt_ff == `MSP_BYTE_BITS);
	// Read data moves in the data phase and after it, never in pointer or subpointer
	assign shift_out = sclk_rise && (state_ff != ST_PTR) && (state_ff != ST_SUB) &&
		rd_flag_ff;

	// Next phase and bit position within the frame
	always @* begin
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		if (cs_n_q) begin
			// Deselect returns to the pointer byte
			nxt_state = ST_PTR;
			nxt_bit_cnt = 5'h00;
		end else if (sclk_fall) begin
			case (state_ff)
				ST_PTR: begin
					if (ptr_done) begin
						nxt_bit_cnt = 5'h00;
						if (null_ptr) begin
							nxt_state = ST_DONE;
						end else if (ptr_in_bank) begin
							nxt_state = ST_SUB;
						end else begin
							nxt_state = ST_DATA;
						end
					end else begin
						nxt_bit_cnt = bit_cnt_ff + 5'h01;
					end
				end
				ST_SUB: begin
					if (sub_done) begin
						nxt_bit_cnt = 5'h00;
						nxt_state = ST_DATA;
					end else begin
						nxt_bit_cnt = bit_cnt_ff + 5'h01;
					end
				end
				ST_DATA: begin
					if (word_done) begin
						nxt_bit_cnt = `MSP_WORD_BITS;
						nxt_state = ST_DONE;
					end else begin
						nxt_bit_cnt = bit_cnt_ff + 5'h01;
					end
				end
				default: begin
					// Surplus bits after the access are ignored
					nxt_state = ST_DONE;
				end
			endcase
		end
	end

	// Frame sequencer registers
	always @(posedge sys_clk) begin
		if (rst) begin
			state_ff <= ST_PTR;
			bit_cnt_ff <= 5'h00;
		end else begin
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
		end
	end

	// Pointer and subpointer capture, register-space strobes
	always @(posedge sys_clk) begin
		if (rst) begin
			rd_flag_ff <= 1'b0;
			wr_flag_ff <= 1'b0;
			ptr_update_ff <= 1'b0;
			seq_reinit_ff <= 1'b0;
			reg_addr_ff <= `MSP_RST_ADDR;
			reg_sub_ff <= `MSP_RST_SUB;
			reg_banked_ff <= 1'b0;
			reg_rd_en_ff <= 1'b0;
		end else begin
			ptr_update_ff <= ptr_done;
			seq_reinit_ff <= ptr_done & null_ptr;
			// Unbanked reads fetch after the pointer, banked ones after the subpointer
			reg_rd_en_ff <= (ptr_done & ~ptr_in_bank & byte_in[`MSP_PTR_RD_BIT]) |
				(sub_done & rd_flag_ff);
			if (cs_n_q) begin
				rd_flag_ff <= 1'b0;
				wr_flag_ff <= 1'b0;
			end else if (ptr_done) begin
				rd_flag_ff <= byte_in[`MSP_PTR_RD_BIT];
				wr_flag_ff <= byte_in[`MSP_PTR_WR_BIT];
				reg_addr_ff <= byte_in[`MSP_PTR_ADDR_HI:`MSP_PTR_ADDR_LO];
				reg_banked_ff <= ptr_in_bank;
			end
			if (sub_done) begin
				reg_sub_ff <= byte_in;
			end
		end
	end

	// Incoming shift register and write commit
	always @(posedge sys_clk) begin
		if (rst) begin
			rx_ff <= `MSP_RST_WORD;
			reg_wr_en_ff <= 1'b0;
			reg_wr_byte_ff <= 1'b0;
			reg_wr_data_ff <= `MSP_RST_WORD;
		end else begin
			reg_wr_en_ff <= 1'b0;
			reg_wr_byte_ff <= 1'b0;
			if (sclk_fall) begin
				rx_ff <= {rx_ff[14:0], din_q};
			end
			if (word_done && wr_flag_ff) begin
				// A full word commits a 16-bit write
				reg_wr_en_ff <= 1'b1;
				reg_wr_data_ff <= {rx_ff[14:0], din_q};
			end else if (byte_end) begin
				// A whole data byte ending the frame writes an 8-bit subregister
				reg_wr_en_ff <= 1'b1;
				reg_wr_byte_ff <= 1'b1;
				reg_wr_data_ff <= {8'h00, rx_ff[7:0]};
			end
		end
	end

	// Read word load and outgoing shift
	always @(posedge sys_clk) begin
		if (rst) begin
			rd_pend_ff <= 1'b0;
			tx_ff <= `MSP_RST_WORD;
			dout_ff <= 1'b0;
			dout_oe_ff <= 1'b0;
		end else begin
			// Read word arrives the cycle after the request
			rd_pend_ff <= reg_rd_en_ff;
			if (cs_n_q) begin
				// Output released while deselected
				dout_ff <= 1'b0;
				dout_oe_ff <= 1'b0;
			end else if (shift_out) begin
				// Read data out D15 first, changing on the rising edge
				dout_ff <= tx_ff[15];
				dout_oe_ff <= 1'b1;
			end
			// Shift beats a pending load; the load lands well before the first rise
			if (shift_out) begin
				tx_ff <= {tx_ff[14:0], 1'b0};
			end else if (rd_pend_ff) begin
				tx_ff <= reg_rd_data;
			end
		end
	end

	// Select fall marks the start of transfer and conversion
	always @(posedge sys_clk) begin
		if (rst) begin
			frame_start_ff <= 1'b0;
		end else begin
			frame_start_ff <= cs_fall;
		end
	end

	assign spi_dout = dout_ff;
	assign spi_dout_oe = dout_oe_ff;
	assign frame_start = frame_start_ff;
	assign ptr_update = ptr_update_ff;
	assign seq_reinit = seq_reinit_ff;
	assign reg_addr = reg_addr_ff;
	assign reg_sub = reg_sub_ff;
	assign reg_banked = reg_banked_ff;
	assign reg_rd_en = reg_rd_en_ff;
	assign reg_wr_en = reg_wr_en_ff;
	assign reg_wr_byte = reg_wr_byte_ff;
	assign reg_wr_data = reg_wr_data_ff;
endmodule // msp_spi_port

// [hdl/msp_defines.vh]
// Constants for the monitor serial register port
`ifndef MSP_DEFINES_VH
`define MSP_DEFINES_VH
`define MSP_PTR_RD_BIT 7
`define MSP_PTR_WR_BIT 6
`define MSP_PTR_ADDR_HI 5
`define MSP_PTR_ADDR_LO 0
`define MSP_BYTE_BITS 5'h08
`define MSP_WORD_BITS 5'h10
`define MSP_BANK_LO 6'h05
`define MSP_BANK_HI 6'h09
`define MSP_SYNC_STAGES 2
`define MSP_RST_ADDR 6'h00
`define MSP_RST_SUB 8'h00
`define MSP_RST_WORD 16'h0000
`endif

// [hdl/msp_sync.v]
// Two flip-flop synchroniser for pin inputs, one chain per bit
module msp_sync #(
	parameter WIDTH = 3,
	parameter RST_VAL = 3'h0
) (
	input wire sys_clk,
	input wire rst,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
			reg meta_ff;
			reg stable_ff;
			always @(posedge sys_clk) begin
				if (rst) begin
					meta_ff <= RST_VAL[gi];
					stable_ff <= RST_VAL[gi];
				end else begin
					meta_ff <= async_in[gi];
					stable_ff <= meta_ff;
				end
			end
			assign sync_out[gi] = stable_ff;
		end
	endgenerate
endmodule // msp_sync

// [dv/msp_spi_port_asserts.sv]
// Checker for the serial register port
module msp_spi_port_asserts (
	input wire sys_clk,
	input wire rst,
	input wire spi_cs_n,
	input wire spi_sclk,
	input wire spi_dout,
	input wire spi_dout_oe,
	input wire frame_start,
	input wire ptr_update,
	input wire seq_reinit,
	input wire [5:0] reg_addr,
	input wire reg_banked,
	input wire reg_wr_en,
	input wire reg_wr_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_off; spi_cs_n [*5] |-> !spi_dout_oe; endproperty
	a_off: assert property (p_off) else $error("dout driven while deselected");
	property p_fs; $fell(spi_cs_n) |-> ##[1:5] frame_start; endproperty
	a_fs: assert property (p_fs) else $error("no frame start");
	property p_chg; spi_dout_oe && $changed(spi_dout) |-> $past(spi_sclk) && $past(spi_sclk, 2);
	endproperty
	a_chg: assert property (p_chg) else $error("dout moved off clock rise");
	property p_oe; $rose(spi_dout_oe) |-> !spi_cs_n && $past(spi_sclk); endproperty
	a_oe: assert property (p_oe) else $error("dout enabled out of frame");
	property p_seq; seq_reinit |-> ptr_update; endproperty
	a_seq: assert property (p_seq) else $error("reinit without pointer");
	property p_ptr; ptr_update |=> !ptr_update; endproperty
	a_ptr: assert property (p_ptr) else $error("pointer pulse too long");
	property p_bank; ptr_update |=> reg_banked == (reg_addr >= 6'h05 && reg_addr <= 6'h09);
	endproperty
	a_bank: assert property (p_bank) else $error("bank flag wrong");
	property p_wrb; reg_wr_byte |-> reg_wr_en; endproperty
	a_wrb: assert property (p_wrb) else $error("byte flag without write");
endmodule // msp_spi_port_asserts
bind msp_spi_port msp_spi_port_asserts i_msp_spi_port_asserts (.sys_clk, .rst, .spi_cs_n,
	.spi_sclk, .spi_dout, .spi_dout_oe, .frame_start, .ptr_update, .seq_reinit, .reg_addr,
	.reg_banked, .reg_wr_en, .reg_wr_byte);

// [dv/msp_host.sv]
// Host model driving frames into the serial port
module msp_host (
	input wire sys_clk,
	input wire spi_dout,
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_din
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		spi_cs_n = 1'h1;
		spi_sclk = 1'h0;
		spi_din = 1'h0;
	end
	task automatic hw();
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0;
		spi_cs_n <= 1'h0;
		hw();
		for (int i = 0; i < n; i++) begin
			spi_sclk <= 1'h1;
			spi_din <= tx[n-1-i];
			hw();
			rx = {rx[30:0], spi_dout};
			spi_sclk <= 1'h0;
			hw();
		end
		spi_cs_n <= 1'h1;
		spi_din <= ~spi_din;
		repeat (8) @(posedge sys_clk);
	endtask
endmodule // msp_host

// [dv/tb_top.sv]
// Testbench for the serial register port
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic [15:0] reg_rd_data = 16'h0;
	logic [31:0] rx;
	logic wb;
	int failures = 0;
	int tests_run = 0;
	int wn = 0;
	int sn = 0;
	int fn = 0;
	int rn = 0;
	int pn = 0;
	wire spi_cs_n, spi_sclk, spi_din, spi_dout, spi_dout_oe, frame_start, ptr_update;
	wire seq_reinit, reg_banked, reg_rd_en, reg_wr_en, reg_wr_byte;
	wire [5:0] reg_addr;
	wire [7:0] reg_sub;
	wire [15:0] reg_wr_data;
	wire dout_pin = spi_dout_oe ? spi_dout : 1'hz;
	initial forever #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (reg_wr_en === 1'h1) begin
			wn <= wn + 1;
			wb <= reg_wr_byte;
		end
		if (seq_reinit === 1'h1) sn <= sn + 1;
		if (frame_start === 1'h1) fn <= fn + 1;
		if (reg_rd_en === 1'h1) rn <= rn + 1;
		if (ptr_update === 1'h1) pn <= pn + 1;
	end
	msp_spi_port i_msp_spi_port (.sys_clk, .rst, .spi_cs_n, .spi_sclk, .spi_din, .spi_dout,
		.spi_dout_oe, .frame_start, .ptr_update, .seq_reinit, .reg_addr, .reg_sub, .reg_banked,
		.reg_rd_en, .reg_rd_data, .reg_wr_en, .reg_wr_byte, .reg_wr_data);
	msp_host i_msp_host (.sys_clk, .spi_dout(dout_pin), .spi_cs_n, .spi_sclk, .spi_din);
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task wrap_up;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task t_null;
		i_msp_host.frame(8, 32'h0b, rx);
		chk("null dout", 32'h000000zz, rx);
		chk("frames", 32'h1, fn);
		chk("ptr pulses", 32'h1, pn);
		chk("null addr", 32'h0b, {26'h0, reg_addr});
		chk("reinit", 32'h1, sn);
	endtask
	task t_write;
		i_msp_host.frame(24, 32'h431234, rx);
		chk("wr dout", 32'h00zzzzzz, rx);
		chk("wr data", 32'h1234, {16'h0, reg_wr_data});
		chk("wr count", 32'h1, wn);
	endtask
	task t_part;
		i_msp_host.frame(20, 32'h43abc, rx);
		chk("part count", 32'h1, wn);
	endtask
	task t_read;
		reg_rd_data <= 16'ha5c3;
		i_msp_host.frame(24, 32'h810000, rx);
		chk("rd dout", 32'h00zza5c3, rx);
		chk("rd req", 32'h1, rn);
		chk("rd bank", 32'h0, {31'h0, reg_banked});
		chk("rd addr", 32'h01, {26'h0, reg_addr});
	endtask
	task t_rw;
		reg_rd_data <= 16'h5a5a;
		i_msp_host.frame(32, 32'hc510beef, rx);
		chk("rw dout", 32'hzzzz5a5a, rx);
		chk("rw sub", 32'h10, {24'h0, reg_sub});
		chk("rw req", 32'h2, rn);
		chk("rw bank", 32'h1, {31'h0, reg_banked});
		chk("rw data", 32'hbeef, {16'h0, reg_wr_data});
	endtask
	task t_byte;
		i_msp_host.frame(24, 32'h45207e, rx);
		chk("byte data", 32'h7e, {24'h0, reg_wr_data[7:0]});
		chk("byte flag", 32'h1, {31'h0, wb});
	endtask
	initial begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		wrap_up;
	end
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'h0;
		repeat (4) @(posedge sys_clk);
		chk("idle oe", 32'h0, {31'h0, spi_dout_oe});
		t_null;
		t_write;
		t_part;
		t_read;
		t_rw;
		t_byte;
		wrap_up;
	end
endmodule // tb_top
